// [core/dirt_tracker.sv]
// rename bookkeeping: flag dependency, zeroing idioms, dispatch spacing,
// microcode overhead, latency class, dividend and address composition
// assumes decode presents one op per cycle with req_valid; back-pressure through seg_stall, and through np_ready for np_valid
module dirt_tracker
(
  input wire logic clock,
  input wire logic rst,
  input wire dirt_pkg::dirt_variant_t variant,
  input wire logic req_valid,
  input wire dirt_pkg::dirt_req_t req,
  input wire logic seg_done,
  input wire logic np_valid,
  input wire logic sext_wide,
  input wire logic [dirt_pkg::DIRT_DATA_W-1:0] acc,
  input wire dirt_pkg::dirt_agu_t agu,
  output logic rsp_valid,
  output dirt_pkg::dirt_rsp_t rsp,
  output logic seg_stall,
  output logic np_ready,
  output logic [dirt_pkg::DIRT_DATA_W-1:0] hi_ff,
  output logic [dirt_pkg::DIRT_DATA_W-1:0] addr_ff
);
  import dirt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // idiom table per variant, used for the response and for ready
  function automatic logic is_idiom(dirt_variant_t v, dirt_op_t o);
    logic r;
    r = 1'b0;
    case (v)
      // RULE_03: full idiom set
      DIRT_VAR_NEWEST:
      begin
        r = (o == DIRT_OP_XOR) || (o == DIRT_OP_SUB) || (o == DIRT_OP_XORPS) ||
            (o == DIRT_OP_XORPD) || (o == DIRT_OP_PXOR) || (o == DIRT_OP_SUBP) ||
            (o == DIRT_OP_PSUB);
      end
      // RULE_04: low-power subset
      DIRT_VAR_LOWPWR:
      begin
        r = (o == DIRT_OP_XOR) || (o == DIRT_OP_SUB) || (o == DIRT_OP_XORPS) ||
            (o == DIRT_OP_PXOR);
      end
      // RULE_05: deep subset
      // RULE_06: floating xor deliberately absent
      DIRT_VAR_DEEP:
      begin
        r = (o == DIRT_OP_XOR) || (o == DIRT_OP_SUB) || (o == DIRT_OP_PXOR);
      end
      // mobile: no idiom support is described, stay conservative
      DIRT_VAR_MOBILE:
      begin
        r = 1'b0;
      end
      default:
      begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction : is_idiom

  ////////////////////////////////////////////////////////////////////////////
  // flag producer tracking
  logic flag_pend_ff;                 // a flag producer is known
  logic nxt_flag_pend;
  logic [DIRT_TAG_W-1:0] flag_tag_ff; // newest flag producer
  logic [DIRT_TAG_W-1:0] nxt_flag_tag;
  logic take;                         // op accepted this cycle

  // segment rename level busy
  logic seg_busy_ff;
  logic nxt_seg_busy;

  // a second segment write must wait for the first to finish
  always_comb
  begin
    // RULE_13: one level of segment rename
    seg_stall = req_valid && (req.op == DIRT_OP_SEGWR) && seg_busy_ff;
    take = req_valid && !seg_stall;
  end

  always_comb
  begin
    nxt_flag_pend = flag_pend_ff;
    nxt_flag_tag = flag_tag_ff;
    nxt_seg_busy = seg_busy_ff;
    if (seg_done)
    begin
      nxt_seg_busy = 1'b0;
    end
    // set wins over the completion pulse
    if (take && (req.op == DIRT_OP_SEGWR))
    begin
      nxt_seg_busy = 1'b1;
    end
    if (take && req.writes_flags)
    begin
      nxt_flag_pend = 1'b1;
      nxt_flag_tag = req.tag;
    end
  end

  // state registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flag_pend_ff <= 1'b0;
      flag_tag_ff <= DIRT_TAG_RST;
      seg_busy_ff <= 1'b0;
    end
    else
    begin
      flag_pend_ff <= nxt_flag_pend;
      flag_tag_ff <= nxt_flag_tag;
      seg_busy_ff <= nxt_seg_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response computation
  dirt_rsp_t nxt_rsp;
  logic nxt_rsp_valid;

  always_comb
  begin
    nxt_rsp = '0;
    nxt_rsp_valid = take;
    nxt_rsp.idiom = req.same_reg && is_idiom(variant, req.op);
    nxt_rsp.src_tag = req.src_tag;
    // RULE_14: idiom sources ready at once
    nxt_rsp.srcs_ready = nxt_rsp.idiom || req.src_ready;
    // RULE_01: partial writer merges old flags
    // RULE_02: add and subtract need no flags
    nxt_rsp.flag_dep = (req.op == DIRT_OP_INCDEC) && flag_pend_ff;
    nxt_rsp.flag_tag = nxt_rsp.flag_dep ? flag_tag_ff : DIRT_TAG_RST;
    nxt_rsp.n_ops = {1'b0, req.n_ops};
    // RULE_08: microcode setup overhead
    if ((variant == DIRT_VAR_DEEP) && (req.n_ops > DIRT_UCODE_LIMIT))
    begin
      nxt_rsp.from_ucode = 1'b1;
      nxt_rsp.n_ops = {1'b0, req.n_ops} + DIRT_UCODE_SETUP;
    end
    case (req.op)
      // RULE_09: one shift latency for both counts
      DIRT_OP_SHIFT:
      begin
        nxt_rsp.latency = DIRT_LAT_SHIFT;
      end
      // RULE_10: rotate by one like a shift
      DIRT_OP_ROT1:
      begin
        nxt_rsp.latency = DIRT_LAT_SHIFT;
      end
      // longer rotates cost more
      DIRT_OP_ROTN:
      begin
        nxt_rsp.latency = DIRT_LAT_ROTN;
      end
      default:
      begin
        nxt_rsp.latency = DIRT_LAT_ALU;
      end
    endcase
  end

  // response registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      rsp_valid <= nxt_rsp_valid;
      rsp <= nxt_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // non-pipelined unit: accepts at most every other cycle
  logic np_busy_ff;
  logic nxt_np_busy;

  always_comb
  begin
    // RULE_07: refuse the cycle after accept
    np_ready = !np_busy_ff;
    nxt_np_busy = np_valid && np_ready;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      np_busy_ff <= 1'b0;
    end
    else
    begin
      np_busy_ff <= nxt_np_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dividend high half and address generation
  logic [DIRT_DATA_W-1:0] nxt_hi;
  logic [DIRT_DATA_W-1:0] nxt_addr;

  always_comb
  begin
    // RULE_11: replicate accumulator sign
    if (sext_wide)
    begin
      nxt_hi = {DIRT_DATA_W{acc[DIRT_DATA_W-1]}};
    end
    else
    begin
      // narrow form fills the low 16 bits with acc[15] and clears the upper 16 bits
      nxt_hi = {16'h0000, {16{acc[15]}}};
    end
    // RULE_12: four operands plus optional segment
    nxt_addr = agu.reloc + agu.imm + agu.base + (agu.index << agu.scale) +
               (agu.segmented ? agu.seg_base : {DIRT_DATA_W{1'b0}});
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      hi_ff <= '0;
      addr_ff <= '0;
    end
    else
    begin
      hi_ff <= nxt_hi;
      addr_ff <= nxt_addr;
    end
  end

endmodule : dirt_tracker

// [core/dirt_pkg.sv]
// package for the dependency and idiom rename tracker
// assumes one core clock and a synchronous active-high reset
// How it works
// RULE_01: partial flag writers depend on prior flags
// RULE_02: add and subtract write all flags
// RULE_03: newest variant zeroing idioms break dependency
// RULE_04: low-power variants clear listed idiom dependency
// RULE_05: deep variant recognises xor, sub, pxor
// RULE_06: deep variant floating xor keeps dependency
// RULE_07: unpipelined unit refuses the following cycle
// RULE_08: deep variant microcode adds four setup ops
// RULE_09: constant and register shifts equal latency
// RULE_10: rotate by one matches shift latency
// RULE_11: sign extension fills high dividend register
// RULE_12: address adds four operands plus segment
// RULE_13: segment registers renamed one level only
// RULE_14: zeroing idiom marks sources ready immediately
package dirt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // core variants
  typedef enum logic [1:0]
  {
    DIRT_VAR_NEWEST = 2'h0,  // wide out-of-order core
    DIRT_VAR_LOWPWR = 2'h1,  // low-power dual and single core
    DIRT_VAR_DEEP = 2'h2,    // older deep-pipeline core
    DIRT_VAR_MOBILE = 2'h3   // mobile core
  } dirt_variant_t;

  // operation classes seen by rename
  typedef enum logic [3:0]
  {
    DIRT_OP_OTHER = 4'h0,
    DIRT_OP_ADD = 4'h1,    // add or subtract, full flag writer
    DIRT_OP_INCDEC = 4'h2, // partial flag writer
    DIRT_OP_XOR = 4'h3,    // integer exclusive-or
    DIRT_OP_SUB = 4'h4,    // integer subtract
    DIRT_OP_XORPS = 4'h5,  // packed single exclusive-or
    DIRT_OP_XORPD = 4'h6,  // packed double exclusive-or
    DIRT_OP_PXOR = 4'h7,   // packed integer exclusive-or
    DIRT_OP_SUBP = 4'h8,   // packed floating subtract
    DIRT_OP_PSUB = 4'h9,   // packed integer subtract, any width
    DIRT_OP_SHIFT = 4'hA,  // shift, constant or register count
    DIRT_OP_ROT1 = 4'hB,   // rotate by one
    DIRT_OP_ROTN = 4'hC,   // rotate by immediate or register
    DIRT_OP_SEXT = 4'hD,   // accumulator sign extension
    DIRT_OP_SEGWR = 4'hE   // segment register write
  } dirt_op_t;

  ////////////////////////////////////////////////////////////////////////////
  localparam int DIRT_TAG_W = 6;                  // producer tag width
  localparam int DIRT_DATA_W = 32;                // integer data width
  localparam logic [2:0] DIRT_UCODE_LIMIT = 3'h4; // ops before microcode
  localparam logic [3:0] DIRT_UCODE_SETUP = 4'h4; // setup ops added
  localparam logic [3:0] DIRT_LAT_SHIFT = 4'h1;   // shift latency
  localparam logic [3:0] DIRT_LAT_ROTN = 4'h4;    // long rotate latency
  localparam logic [3:0] DIRT_LAT_ALU = 4'h1;     // other ops
  localparam logic [DIRT_TAG_W-1:0] DIRT_TAG_RST = 6'h00;

  // one renamed operation from decode
  typedef struct packed
  {
    dirt_op_t op;
    logic same_reg;                 // both sources name the destination
    logic writes_flags;
    logic [2:0] n_ops;              // decoded operation count, 7 = more
    logic [DIRT_TAG_W-1:0] tag;     // tag of this op
    logic [DIRT_TAG_W-1:0] src_tag; // producer of the source register
    logic src_ready;
  } dirt_req_t;

  // answer to reservation station
  typedef struct packed
  {
    logic idiom;                     // dependency broken
    logic srcs_ready;
    logic flag_dep;                  // waits on flag producer
    logic [DIRT_TAG_W-1:0] flag_tag;
    logic [DIRT_TAG_W-1:0] src_tag;
    logic [3:0] n_ops;               // total ops incl. microcode setup
    logic from_ucode;
    logic [3:0] latency;
  } dirt_rsp_t;

  // address operands
  typedef struct packed
  {
    logic [DIRT_DATA_W-1:0] reloc;
    logic [DIRT_DATA_W-1:0] imm;
    logic [DIRT_DATA_W-1:0] base;
    logic [DIRT_DATA_W-1:0] index;
    logic [1:0] scale;               // index shifted by 0..3
    logic [DIRT_DATA_W-1:0] seg_base;
    logic segmented;
  } dirt_agu_t;

endpackage : dirt_pkg

// [tb/dirt_tracker_assertions.sv]
// checker on the rename tracker ports
// assumes one clock and a synchronous active-high reset
module dirt_chk
  import dirt_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire dirt_pkg::dirt_variant_t variant,
  input wire logic req_valid,
  input wire dirt_pkg::dirt_req_t req,
  input wire logic sext_wide,
  input wire logic [dirt_pkg::DIRT_DATA_W-1:0] acc,
  input wire logic rsp_valid,
  input wire dirt_pkg::dirt_rsp_t rsp,
  input wire logic seg_stall,
  input wire logic np_valid,
  input wire logic np_ready,
  input wire logic [dirt_pkg::DIRT_DATA_W-1:0] hi_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // an op is taken when offered and not held off
  logic take;
  assign take = req_valid && !seg_stall;
  sequence seg_take_s;
    take && req.op == DIRT_OP_SEGWR && variant == DIRT_VAR_MOBILE;
  endsequence
  sequence seg_again_s;
    req_valid && req.op == DIRT_OP_SEGWR;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  // unit spacing, flag, idiom, microcode, latency, sign fill and segment hold checks
  np_gap_a: assert property (np_valid && np_ready |=> !np_ready) else $error("np accepted twice");
  add_flags_a: assert property (take && req.op == DIRT_OP_ADD |=> !rsp.flag_dep) else $error("add flag dep");
  new_idiom_a: assert property (take && variant == DIRT_VAR_NEWEST && req.same_reg
    && req.op inside {[DIRT_OP_XOR:DIRT_OP_PSUB]} |=> rsp.idiom) else $error("idiom missed");
  deep_fp_a: assert property (take && variant == DIRT_VAR_DEEP && req.op inside {DIRT_OP_XORPS, DIRT_OP_XORPD}
    |=> !rsp.idiom) else $error("deep fp idiom");
  idiom_rdy_a: assert property (rsp_valid && rsp.idiom |-> rsp.srcs_ready) else $error("idiom not ready");
  ucode_ops_a: assert property (take && variant == DIRT_VAR_DEEP && req.n_ops > 3'h4
    |=> rsp.from_ucode && rsp.n_ops == {1'b0, $past(req.n_ops)} + 4'h4) else $error("ucode count");
  shift_lat_a: assert property (take && req.op inside {DIRT_OP_SHIFT, DIRT_OP_ROT1}
    |=> rsp.latency == DIRT_LAT_SHIFT) else $error("shift latency");
  sign_fill_a: assert property (sext_wide |=> hi_ff == {32{$past(acc[31])}}) else $error("sign fill");
  seg_hold_a: assert property (seg_take_s ##1 seg_again_s |-> seg_stall) else $error("segment not held");
endmodule : dirt_chk

bind dirt_tracker dirt_chk u_chk (.clock, .rst, .variant, .req_valid, .req, .sext_wide, .acc,
  .rsp_valid, .rsp, .seg_stall, .np_valid, .np_ready, .hi_ff);

// [tb/dirt_np_feed.sv]
// partner: decode side offering ops to the non-pipelined unit
// assumes np_ready settles just after each rising edge
module dirt_np_feed
(
  input wire logic clock,
  input wire logic go,
  input wire logic np_ready,
  output logic np_valid,
  output int taken
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    np_valid = 1'b0;
    taken = 0;
  end
  // offer stays up every cycle while go, so refusals show as gaps
  always @(posedge clock)
  begin
    if (np_valid && np_ready)
      taken <= taken + 1;
    np_valid <= #1 go;
  end
endmodule : dirt_np_feed

// [tb/dirt_tracker_bench.sv]
// bench for the rename tracker
// assumes the checker is bound in by its own file
module dirt_tracker_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dirt_pkg::*;
  logic clock, rst, req_valid, seg_done, np_valid, sext_wide, rsp_valid, seg_stall, np_ready, go;
  dirt_variant_t variant;
  dirt_req_t req;
  dirt_rsp_t rsp;
  dirt_agu_t agu;
  logic [31:0] acc, hi_ff, addr_ff;
  int fails, n_checks, taken;
  dirt_tracker DUT (.clock(clock), .rst(rst), .variant(variant), .req_valid(req_valid), .req(req),
    .seg_done(seg_done), .np_valid(np_valid), .sext_wide(sext_wide), .acc(acc), .agu(agu),
    .rsp_valid(rsp_valid), .rsp(rsp), .seg_stall(seg_stall), .np_ready(np_ready), .hi_ff(hi_ff),
    .addr_ff(addr_ff));
  dirt_np_feed u_feed (.clock(clock), .go(go), .np_ready(np_ready), .np_valid(np_valid), .taken(taken));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic end_sim();
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // one op per two cycles; the answer is left standing on return
  task automatic issue(dirt_op_t op, logic sr, logic wf, logic [2:0] n, logic [5:0] tg);
    @(posedge clock);
    #1;
    req = '{op, sr, wf, n, tg, 6'h3F, 1'b0};
    req_valid = 1'b1;
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    chk("rsp_valid", rsp_valid, 1);
  endtask : issue
  function automatic logic id_exp(dirt_variant_t v, dirt_op_t o);
    case (v)
      DIRT_VAR_NEWEST: return o inside {[DIRT_OP_XOR:DIRT_OP_PSUB]};
      DIRT_VAR_LOWPWR: return o inside {DIRT_OP_XOR, DIRT_OP_SUB, DIRT_OP_XORPS, DIRT_OP_PXOR};
      DIRT_VAR_DEEP: return o inside {DIRT_OP_XOR, DIRT_OP_SUB, DIRT_OP_PXOR};
      default: return 1'b0;
    endcase
  endfunction : id_exp
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_flags();
    issue(DIRT_OP_INCDEC, 0, 1, 1, 6'h01);
    chk("flag_dep", rsp.flag_dep, 0);
    issue(DIRT_OP_ADD, 0, 1, 1, 6'h05);
    chk("flag_dep", rsp.flag_dep, 0);
    issue(DIRT_OP_INCDEC, 0, 1, 1, 6'h06);
    chk("flag_tag", {rsp.flag_dep, rsp.flag_tag}, 7'h45);
    issue(DIRT_OP_ADD, 0, 1, 1, 6'h07);
    chk("flag_dep", rsp.flag_dep, 0);
    issue(DIRT_OP_INCDEC, 0, 0, 1, 6'h08);
    chk("flag_tag", {rsp.flag_dep, rsp.flag_tag}, 7'h47);
  endtask : t_flags
  task automatic t_idiom();
    for (int v = 0; v < 4; v++)
      for (int o = 3; o < 10; o++)
      begin
        variant = dirt_variant_t'(v);
        issue(dirt_op_t'(o), 1, 0, 1, 6'h02);
        chk("idiom", rsp.idiom, id_exp(variant, dirt_op_t'(o)));
        chk("srcs_ready", rsp.srcs_ready, id_exp(variant, dirt_op_t'(o)));
      end
    // deep core: an exclusive-or on distinct registers keeps its dependency
    variant = DIRT_VAR_DEEP;
    issue(DIRT_OP_XOR, 0, 0, 1, 6'h03);
    chk("idiom", rsp.idiom, 0);
  endtask : t_idiom
  task automatic t_ucode();
    // microcode overhead only exists on the deep core
    variant = DIRT_VAR_DEEP;
    issue(DIRT_OP_OTHER, 0, 0, 4, 6'h04);
    chk("ucode", {rsp.from_ucode, rsp.n_ops}, 5'h04);
    issue(DIRT_OP_OTHER, 0, 0, 7, 6'h04);
    chk("ucode", {rsp.from_ucode, rsp.n_ops}, 5'h1B);
    variant = DIRT_VAR_NEWEST;
    issue(DIRT_OP_OTHER, 0, 0, 5, 6'h04);
    chk("ucode", {rsp.from_ucode, rsp.n_ops}, 5'h05);
    issue(DIRT_OP_SHIFT, 0, 1, 1, 6'h0A);
    chk("latency", rsp.latency, DIRT_LAT_SHIFT);
    issue(DIRT_OP_ROT1, 0, 1, 1, 6'h0B);
    chk("latency", rsp.latency, DIRT_LAT_SHIFT);
    issue(DIRT_OP_ROTN, 0, 1, 1, 6'h0C);
    chk("latency", rsp.latency, DIRT_LAT_ROTN);
  endtask : t_ucode
  task automatic t_data();
    acc = 32'h80008000;
    sext_wide = 1'b1;
    agu = '{32'h10, 32'h20, 32'h100, 32'h3, 2'h2, 32'h1000, 1'b1};
    @(posedge clock);
    #1;
    chk("hi_ff", hi_ff, 32'hFFFFFFFF);
    chk("addr_ff", addr_ff, 32'h113C);
    sext_wide = 1'b0;
    agu.segmented = 1'b0;
    @(posedge clock);
    #1;
    chk("hi_ff", hi_ff, 32'h0000FFFF);
    chk("addr_ff", addr_ff, 32'h13C);
    acc = 32'h7FFF7FFF;
    sext_wide = 1'b1;
    agu = '{32'h10, 32'h0, 32'hFFFFFFF0, 32'h40000000, 2'h3, 32'h5, 1'b0};
    @(posedge clock);
    #1;
    chk("hi_ff", hi_ff, 32'h0);
    chk("addr_ff", addr_ff, 32'h0);
  endtask : t_data
  task automatic t_seg();
    variant = DIRT_VAR_MOBILE;
    req = '{DIRT_OP_SEGWR, 1'b0, 1'b0, 3'h1, 6'h09, 6'h00, 1'b1};
    req_valid = 1'b1;
    @(posedge clock);
    #1;
    chk("seg_stall", {rsp_valid, seg_stall}, 2'h3);
    @(posedge clock);
    #1;
    chk("rsp_valid", rsp_valid, 0);
    seg_done = 1'b1;
    @(posedge clock);
    #1;
    seg_done = 1'b0;
    chk("seg_stall", seg_stall, 0);
    @(posedge clock);
    #1;
    chk("rsp_valid", rsp_valid, 1);
    req_valid = 1'b0;
    go = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    go = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("np taken", taken, 5);
  endtask : t_seg
  initial
  begin
    rst = 1'b1;
    variant = DIRT_VAR_NEWEST;
    req_valid = 1'b0;
    req = '0;
    seg_done = 1'b0;
    sext_wide = 1'b0;
    acc = '0;
    agu = '0;
    go = 1'b0;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("np_ready", {rsp_valid, np_ready}, 2'h1);
    t_flags();
    t_idiom();
    t_ucode();
    t_data();
    t_seg();
    end_sim();
  end
  // watchdog: the run needs well under 200 cycles
  initial
  begin
    #100000;
    fails++;
    end_sim();
  end
endmodule : dirt_tracker_bench
